// File: hdl/jcfg_pkg.sv
// constants, types and opcodes shared by the configuration instruction unit
package jcfg_pkg;

  // instruction register and chain widths
  localparam int          JCFG_IR_W       = 10;
  localparam int          JCFG_BSR_LEN    = 174;
  localparam int          JCFG_ID_W       = 32;
  localparam int          JCFG_SYNC_STAGES = 2;

  // instruction opcodes
  localparam logic [9:0]  JCFG_OP_SAMPLE  = 10'h055;
  localparam logic [9:0]  JCFG_OP_EXTEST  = 10'h000;
  localparam logic [9:0]  JCFG_OP_BYPASS  = 10'h3FF;
  localparam logic [9:0]  JCFG_OP_IDCODE  = 10'h059;
  localparam logic [9:0]  JCFG_OP_USER    = 10'h079;
  localparam logic [9:0]  JCFG_OP_INIT    = 10'h061;
  localparam logic [9:0]  JCFG_OP_HOLD    = 10'h065;

  // value loaded into the instruction shifter on capture
  localparam logic [9:0]  JCFG_IR_CAPTURE = 10'h001;
  // instruction after reset or test-logic-reset
  localparam logic [9:0]  JCFG_IR_RESET   = JCFG_OP_IDCODE;
  // identification code, arbitrary value with mandatory lsb of one
  localparam logic [31:0] JCFG_IDCODE_DEF = 32'h0A5C_3E01;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } jcfg_tap_e;

  // data register selected by the current instruction
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_USER, SEL_BSR
  } jcfg_sel_e;

  // the three test port inputs travelling together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jcfg_tap_pins_s;

endpackage : jcfg_pkg

// File: hdl/jcfg_sync.sv
// two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module jcfg_sync
  import jcfg_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : jcfg_sync

// File: hdl/jcfg_unit.sv
// test access port, instruction decode, scan registers and configuration-initiate drive
`timescale 1ns/1ps
module jcfg_unit
  import jcfg_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = JCFG_IDCODE_DEF  // arbitrary identification value
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    por_done,
  input  wire jcfg_tap_pins_s          tap_pins,
  output logic                         tdo,
  output logic                         tdo_oe,
  input  wire logic [JCFG_ID_W-1:0]    usercode_value,
  input  wire logic [JCFG_BSR_LEN-1:0] pin_in,
  input  wire logic [JCFG_BSR_LEN-1:0] core_out,
  output logic      [JCFG_BSR_LEN-1:0] pin_out,
  output logic                         extest_active,
  output logic                         init_conf_out,
  output logic                         init_conf_oe
);

  jcfg_tap_pins_s            pins_s;
  logic [JCFG_BSR_LEN-1:0]   pin_s;
  logic                      tck_d_r;
  logic                      tck_rise;
  logic                      tck_fall;
  jcfg_tap_e                 tap_state_r;
  jcfg_tap_e                 tap_nxt;
  logic [JCFG_IR_W-1:0]      ir_shift_r;
  logic [JCFG_IR_W-1:0]      ir_r;
  jcfg_sel_e                 sel;
  logic                      bypass_r;
  logic [JCFG_ID_W-1:0]      id_shift_r;
  logic [JCFG_BSR_LEN-1:0]   bsr_shift_r;
  logic [JCFG_BSR_LEN-1:0]   bsr_upd_r;
  logic                      hold_r;
  logic                      tdo_bit;

  // test port pins and boundary inputs come from outside this clock
  jcfg_sync #(.WIDTH(3)) u_sync_tap (
    .clk      (clk),
    .rst      (rst),
    .async_in (tap_pins),
    .sync_out (pins_s)
  );

  jcfg_sync #(.WIDTH(JCFG_BSR_LEN)) u_sync_pins (
    .clk      (clk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_s)
  );

  // tck edge detection on the synchronised level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= pins_s.tck;
    end
  end

  assign tck_rise = pins_s.tck & ~tck_d_r;
  assign tck_fall = ~pins_s.tck & tck_d_r;

  // standard controller transitions on tms
  always_comb begin
    tap_nxt = tap_state_r;
    case (tap_state_r)
      TAP_RESET:  tap_nxt = pins_s.tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_nxt = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = pins_s.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = pins_s.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_nxt = pins_s.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_nxt = pins_s.tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_nxt = pins_s.tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_nxt = pins_s.tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_nxt = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = pins_s.tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = pins_s.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_nxt = pins_s.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_nxt = pins_s.tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_nxt = pins_s.tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_nxt = pins_s.tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_nxt = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_nxt = TAP_RESET;
    endcase
  end

  // controller advances on tck rise, held in reset until power-on completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_state_r <= TAP_RESET;
    end else if (!por_done) begin
      tap_state_r <= TAP_RESET;
    end else if (tck_rise) begin
      tap_state_r <= tap_nxt;
    end
  end

  // instruction shifter: capture fixed pattern, shift ten bits lsb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_shift_r <= JCFG_IR_CAPTURE;
    end else if (tck_rise && tap_state_r == TAP_CAP_IR) begin
      ir_shift_r <= JCFG_IR_CAPTURE;
    end else if (tck_rise && tap_state_r == TAP_SH_IR) begin
      ir_shift_r <= {pins_s.tdi, ir_shift_r[JCFG_IR_W-1:1]};
    end
  end

  // instruction latch updates on tck fall in update-ir
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_r <= JCFG_IR_RESET;
    end else if (tap_state_r == TAP_RESET) begin
      ir_r <= JCFG_IR_RESET;
    end else if (tck_fall && tap_state_r == TAP_UPD_IR) begin
      ir_r <= ir_shift_r;
    end
  end

  // data register selection; unlisted opcodes fall back to bypass
  always_comb begin
    case (ir_r)
      JCFG_OP_SAMPLE: sel = SEL_BSR;
      JCFG_OP_EXTEST: sel = SEL_BSR;
      JCFG_OP_IDCODE: sel = SEL_IDCODE;
      JCFG_OP_USER:   sel = SEL_USER;
      default:        sel = SEL_BYPASS;
    endcase
  end

  // one-bit bypass stage: cleared on capture, takes tdi on shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bypass_r <= 1'b0;
    end else if (tck_rise && sel == SEL_BYPASS && tap_state_r == TAP_CAP_DR) begin
      bypass_r <= 1'b0;
    end else if (tck_rise && sel == SEL_BYPASS && tap_state_r == TAP_SH_DR) begin
      bypass_r <= pins_s.tdi;
    end
  end

  // identification and user code share one 32-bit shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_shift_r <= '0;
    end else if (tck_rise && tap_state_r == TAP_CAP_DR && sel == SEL_IDCODE) begin
      id_shift_r <= IDCODE_VALUE;
    end else if (tck_rise && tap_state_r == TAP_CAP_DR && sel == SEL_USER) begin
      id_shift_r <= usercode_value;
    end else if (tck_rise && tap_state_r == TAP_SH_DR && (sel == SEL_IDCODE || sel == SEL_USER)) begin
      id_shift_r <= {pins_s.tdi, id_shift_r[JCFG_ID_W-1:1]};
    end
  end

  // boundary chain captures synchronised pins and shifts 174 cells
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_shift_r <= '0;
    end else if (tck_rise && tap_state_r == TAP_CAP_DR && sel == SEL_BSR) begin
      bsr_shift_r <= pin_s;
    end else if (tck_rise && tap_state_r == TAP_SH_DR && sel == SEL_BSR) begin
      bsr_shift_r <= {pins_s.tdi, bsr_shift_r[JCFG_BSR_LEN-1:1]};
    end
  end

  // update stage loads on tck fall; preload under sample keeps pins untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_upd_r <= '0;
    end else if (tck_fall && tap_state_r == TAP_UPD_DR && sel == SEL_BSR) begin
      bsr_upd_r <= bsr_shift_r;
    end
  end

  // pins follow the core unless extest hands them to the update stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out       <= '0;
      extest_active <= 1'b0;
    end else begin
      extest_active <= (ir_r == JCFG_OP_EXTEST);
      pin_out       <= (ir_r == JCFG_OP_EXTEST) ? bsr_upd_r : core_out;
    end
  end

  // tdo source of the selected path
  always_comb begin
    case (tap_state_r)
      TAP_SH_IR: tdo_bit = ir_shift_r[0];
      default: begin
        case (sel)
          SEL_IDCODE: tdo_bit = id_shift_r[0];
          SEL_USER:   tdo_bit = id_shift_r[0];
          SEL_BSR:    tdo_bit = bsr_shift_r[0];
          default:    tdo_bit = bypass_r;
        endcase
      end
    endcase
  end

  // tdo changes on tck fall and is driven only while shifting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= tdo_bit;
      tdo_oe <= (tap_state_r == TAP_SH_IR || tap_state_r == TAP_SH_DR);
    end
  end

  // hold flag: set by hold-configuration update, cleared only by start-configuration update or by rst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (tck_fall && tap_state_r == TAP_UPD_IR && ir_shift_r == JCFG_OP_HOLD) begin
      hold_r <= 1'b1;
    end else if (tck_fall && tap_state_r == TAP_UPD_IR && ir_shift_r == JCFG_OP_INIT) begin
      hold_r <= 1'b0;
    end
  end

  // open-drain initiate pin: pulled low while held or while idling under start-configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_conf_oe <= 1'b0;
    end else begin
      init_conf_oe <= hold_r || (ir_r == JCFG_OP_INIT && tap_state_r == TAP_IDLE);
    end
  end

  // never drives high, the board pull-up releases the target
  assign init_conf_out = 1'b0;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence init_trigger_s;
    (ir_r == JCFG_OP_INIT) && (tap_state_r == TAP_IDLE);
  endsequence

  sequence hold_update_s;
    tck_fall && (tap_state_r == TAP_UPD_IR) && (ir_shift_r == JCFG_OP_HOLD);
  endsequence

  init_pulse_low_a: assert property (init_trigger_s |=> init_conf_oe)
    else $error("initiate pin not low in trigger state");
  init_release_a: assert property ((tap_state_r != TAP_IDLE) && !hold_r |=> !init_conf_oe)
    else $error("initiate pin still driven after leaving trigger state");
  init_no_high_a: assert property (init_conf_out == 1'b0)
    else $error("initiate pin driven high");
  hold_set_a: assert property (hold_update_s |=> hold_r ##1 init_conf_oe)
    else $error("hold instruction did not pull the pin low");
  hold_persist_a: assert property (hold_r && !(tck_fall && tap_state_r == TAP_UPD_IR && ir_shift_r == JCFG_OP_INIT)
    |=> hold_r)
    else $error("hold released without start-configuration");
  ir_capture_a: assert property (tck_rise && tap_state_r == TAP_CAP_IR |=> ir_shift_r == JCFG_IR_CAPTURE)
    else $error("instruction capture pattern wrong");
  bypass_shift_a: assert property (tck_rise && tap_state_r == TAP_SH_DR && sel == SEL_BYPASS
    |=> bypass_r == $past(pins_s.tdi))
    else $error("bypass stage did not take tdi");
  id_capture_a: assert property (tck_rise && tap_state_r == TAP_CAP_DR && ir_r == JCFG_OP_IDCODE
    |=> id_shift_r == IDCODE_VALUE)
    else $error("identification code not captured");
  user_capture_a: assert property (tck_rise && tap_state_r == TAP_CAP_DR && ir_r == JCFG_OP_USER
    |=> id_shift_r == $past(usercode_value))
    else $error("user code not captured");
  extest_drive_a: assert property (ir_r == JCFG_OP_EXTEST |=> pin_out == $past(bsr_upd_r))
    else $error("extest pins not from update stage");
  sample_quiet_a: assert property (ir_r == JCFG_OP_SAMPLE |=> pin_out == $past(core_out))
    else $error("sample disturbed the pins");
  bsr_capture_a: assert property (tck_rise && tap_state_r == TAP_CAP_DR && sel == SEL_BSR
    |=> bsr_shift_r == $past(pin_s))
    else $error("boundary chain capture wrong");
  por_hold_a: assert property (!por_done |=> tap_state_r == TAP_RESET)
    else $error("controller left reset before power-on done");

endmodule : jcfg_unit

// File: testbench/jcfg_host.sv
// jtag host model driving the test access port
`timescale 1ns/1ps
module jcfg_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // link clock stands low between frames, tdi idles at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period of 125 ns, tdo taken at the rising edge
  task automatic tbit(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo;
    #62.5 tck = 1'b0;
  endtask : tbit
  // state walk, tms values lsb first
  task automatic walk(input logic [4:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++) tbit(m[i], 1'b1, q);
  endtask : walk
  // shift n bits through ir or dr starting and ending in run-test/idle
  task automatic scan(input logic ir, input logic [173:0] din, input int n, output logic [173:0] dout);
    logic q;
    dout = '0;
    if (ir) walk(5'h03, 4);
    else walk(5'h01, 3);
    for (int i = 0; i < n; i++) begin
      tbit(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(5'h01, 2);
  endtask : scan
endmodule : jcfg_host

// File: testbench/tb_jcfg_unit.sv
// self-checking bench for the configuration instruction unit
`timescale 1ns/1ps
module tb_jcfg_unit;
  import jcfg_pkg::*;
  localparam logic [31:0]  ID_V = 32'h1234_5679;  // arbitrary identification value
  logic                    clk, rst, por_done, tck, tms, tdi, tdo, tdo_oe;
  logic                    extest_active, init_conf_out, init_conf_oe;
  logic [JCFG_ID_W-1:0]    usercode_value;
  logic [JCFG_BSR_LEN-1:0] pin_in, core_out, pin_out, d, q, pre;
  logic [9:0]              op;
  int                      err_count, cmp_count;
  jcfg_tap_pins_s          pins;

  assign pins = '{tck: tck, tms: tms, tdi: tdi};

  jcfg_unit #(.IDCODE_VALUE(ID_V)) dut (.clk(clk), .rst(rst), .por_done(por_done), .tap_pins(pins), .tdo(tdo),
    .tdo_oe(tdo_oe), .usercode_value(usercode_value), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
    .extest_active(extest_active), .init_conf_out(init_conf_out), .init_conf_oe(init_conf_oe));

  jcfg_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [173:0] e, input logic [173:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [173:0] rnd174();
    return 174'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()});
  endfunction : rnd174

  // bypass captures zero, then echoes tdi one tck late
  function automatic logic [173:0] byp_exp(input logic [173:0] v);
    return 174'({v[7:0], 1'b0});
  endfunction : byp_exp

  function automatic logic [9:0] unlisted();
    logic [9:0] v;
    do v = 10'($urandom()); while (v inside {JCFG_OP_SAMPLE, JCFG_OP_EXTEST, JCFG_OP_BYPASS, JCFG_OP_IDCODE,
      JCFG_OP_USER, JCFG_OP_INIT, JCFG_OP_HOLD});
    return v;
  endfunction : unlisted

  // load an instruction, checking the captured pattern
  task automatic load(input logic [9:0] o);
    logic [173:0] r;
    host.scan(1'b1, 174'(o), 10, r);
    chk("ir_capture", 174'(JCFG_IR_CAPTURE), r);
  endtask : load

  // leave idle for select-dr and report the pin drive afterwards
  task automatic leave_idle(input string nm, input logic e);
    host.walk(5'h01, 1);
    repeat (8) @(negedge clk);
    chk(nm, 174'(e), 174'(init_conf_oe));
    host.walk(5'h03, 3);
  endtask : leave_idle

  // hang guard
  initial begin
    #400000;  // about 50000 clock cycles
    err_count++;
    end_sim();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    por_done = 1'b0;
    usercode_value = '0;
    pin_in = '0;
    core_out = '0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(17));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk) por_done = 1'b1;
    repeat (4) @(negedge clk);
    host.walk(5'h00, 1);
    host.scan(1'b0, '1, 32, q);
    chk("idcode", 174'(ID_V), q);
    @(negedge clk) usercode_value = $urandom();
    load(JCFG_OP_USER);
    host.walk(5'h01, 3);
    repeat (8) @(negedge clk);
    chk("tdo_drive", 174'(1), 174'(tdo_oe));
    host.walk(5'h03, 3);
    host.scan(1'b0, '0, 32, q);
    chk("usercode", 174'(usercode_value), q);
    chk("tdo_release", 174'(0), 174'(tdo_oe));
    for (int k = 0; k < 4; k++) begin
      op = (k == 0) ? JCFG_OP_BYPASS : unlisted();
      load(op);
      d = rnd174();
      host.scan(1'b0, d, 9, q);
      chk("bypass", byp_exp(d), q);
    end
    @(negedge clk) begin
      pin_in = rnd174();
      core_out = rnd174();
    end
    pre = rnd174();
    load(JCFG_OP_SAMPLE);
    host.scan(1'b0, pre, 174, q);
    chk("sample_capture", pin_in, q);
    chk("sample_pins", core_out, pin_out);
    load(JCFG_OP_EXTEST);
    chk("extest_flag", 174'(1), 174'(extest_active));
    chk("extest_preload", pre, pin_out);
    @(negedge clk) pin_in = rnd174();
    d = rnd174();
    repeat (4) @(negedge clk);
    host.scan(1'b0, d, 174, q);
    chk("extest_capture", pin_in, q);
    chk("extest_update", d, pin_out);
    load(JCFG_OP_INIT);
    chk("init_low", 174'(1), 174'(init_conf_oe));
    chk("init_value", 174'(0), 174'(init_conf_out));
    chk("extest_flag_off", 174'(0), 174'(extest_active));
    leave_idle("init_release", 1'b0);
    load(JCFG_OP_HOLD);
    chk("hold_low", 174'(1), 174'(init_conf_oe));
    load(JCFG_OP_IDCODE);
    leave_idle("hold_kept", 1'b1);
    load(JCFG_OP_INIT);
    chk("hold_init_low", 174'(1), 174'(init_conf_oe));
    leave_idle("hold_release", 1'b0);
    // a mid-run reset must drop a pending hold
    load(JCFG_OP_HOLD);
    chk("hold_again", 174'(1), 174'(init_conf_oe));
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset_release", 174'(0), 174'(init_conf_oe));
    end_sim();
  end
endmodule : tb_jcfg_unit
